/* File: mctarb_apb_bfm.sv */
// apb master model standing in for the cpu bus
module mctarb_apb_bfm
(
  // clock
  input  wire logic        pclk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tmo = 1'b0;
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    tmo = (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show the inverse so stale values cannot pass
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : mctarb_apb_bfm

/* File: mctarb_phase.sv */
// two-input phase decoder: both edges of both inputs give a count step
module mctarb_phase
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // external phase inputs, already synchronous to pclk
  input  wire logic ext_phase_in_a,
  input  wire logic ext_phase_in_b,
  // one-cycle step pulses
  output logic      step_up,
  output logic      step_down
);

  logic a_reg;
  logic b_reg;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
    end
    else
    begin
      a_reg <= ext_phase_in_a;
      b_reg <= ext_phase_in_b;
    end
  end

  assign a_rise = ext_phase_in_a & ~a_reg;
  assign a_fall = ~ext_phase_in_a & a_reg;
  assign b_rise = ext_phase_in_b & ~b_reg;
  assign b_fall = ~ext_phase_in_b & b_reg;

  // a simultaneous change on both inputs is a phase error and is dropped
  assign step_up   = (a_rise ^ a_fall) != (b_rise ^ b_fall) &&
                     ((b_rise & ~ext_phase_in_a) | (a_rise & ext_phase_in_b) |
                      (b_fall & ext_phase_in_a) | (a_fall & ~ext_phase_in_b));
  assign step_down = (a_rise ^ a_fall) != (b_rise ^ b_fall) &&
                     ((a_rise & ~ext_phase_in_b) | (b_rise & ext_phase_in_a) |
                      (a_fall & ext_phase_in_b) | (b_fall & ~ext_phase_in_a));

endmodule : mctarb_phase

/* File: mctarb_pkg.sv */
// constants shared by the three-channel timer arbitration block
package mctarb_pkg;
  localparam int          MCTARB_CHANNELS   = 3;
  localparam int          MCTARB_CW         = 16;
  // per-channel register window: channel n at n * stride
  localparam logic [7:0]  CH_STRIDE         = 8'h20;
  localparam logic [4:0]  OFF_COUNTER       = 5'h00;
  localparam logic [4:0]  OFF_GENERAL_A     = 5'h04;
  localparam logic [4:0]  OFF_GENERAL_B     = 5'h08;
  localparam logic [4:0]  OFF_CHAN_CTRL     = 5'h0C;
  localparam logic [4:0]  OFF_IO_CTRL       = 5'h10;
  // shared registers
  localparam logic [7:0]  ADDR_START        = 8'h60;
  localparam logic [7:0]  ADDR_SYNC         = 8'h64;
  localparam logic [7:0]  ADDR_MODE         = 8'h68;
  localparam logic [7:0]  ADDR_STATUS       = 8'h6C;
  localparam logic [7:0]  ADDR_PIN_STATE    = 8'h70;
  // channel_control_reg fields
  localparam int          CC_PRESCALE_LSB   = 0;
  localparam int          CC_CLEAR_LO       = 5;
  localparam int          CC_CLEAR_HI       = 6;
  // io_control_reg fields
  localparam int          IO_ACT_A_LSB      = 0;
  localparam int          IO_CAPTURE_A      = 2;
  localparam int          IO_CAPTURE_B      = 6;
  // mode_reg fields
  localparam int          MODE_PWM_LSB      = 0;
  localparam int          MODE_PHASE        = 6;
  // status layout: three bits per channel
  localparam int          ST_MATCH_A        = 0;
  localparam int          ST_MATCH_B        = 1;
  localparam int          ST_WRAP           = 2;
  localparam int          ST_PER_CH         = 3;
  // clear select codes
  localparam logic [1:0]  CLR_NONE          = 2'h0;
  localparam logic [1:0]  CLR_ON_A          = 2'h1;
  localparam logic [1:0]  CLR_ON_B          = 2'h2;
  localparam logic [1:0]  CLR_SYNC          = 2'h3;
  // compare output actions
  localparam logic [1:0]  ACT_NONE          = 2'h0;
  localparam logic [1:0]  ACT_LOW           = 2'h1;
  localparam logic [1:0]  ACT_HIGH          = 2'h2;
  localparam logic [1:0]  ACT_TOGGLE        = 2'h3;
  localparam logic [15:0] CNT_MAX           = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO          = 16'h0000;
  localparam int          PRESCALE_TAPS     = 4;
endpackage : mctarb_pkg

/* File: mctarb_prescale.sv */
// free-running divider giving count enables at pclk/1, /2, /4 and /8
module mctarb_prescale
  import mctarb_pkg::*;
#(
  parameter int TAPS = PRESCALE_TAPS
)
(
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // one-cycle enables, tap n fires every 2**n cycles
  output logic [TAPS-1:0]      tick
);

  logic [TAPS-1:0] div_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= '0;
    else
      div_reg <= div_reg + {{(TAPS-1){1'b0}}, 1'b1};
  end

  // tap n fires when the low n bits are all ones
  always_comb
  begin
    for (int n = 0; n < TAPS; n++)
      tick[n] = (n == 0) ? 1'b1 : &(div_reg | ~TAPS'((1 << n) - 1));
  end

endmodule : mctarb_prescale

/* File: mctarb_timer.sv */
// three-channel 16-bit timer with bus-versus-event arbitration, apb slave
//
// Summary of operation
// - clear beats counter write in access phase
// - word write beats count pulse in access
// - byte write blocks counting in setup, access
// - general register write suppresses coincident compare match
// - write beats wrap count, wrap flag still set
// - read during capture returns pre-capture value
// - capture clear beats count, old count captured
// - capture beats general register write
// - compare clear replaces step, period N+1
// - synced byte write copies whole addressed counter
// - sync bit makes writes preset all synced
// - clear select 01 A, 10 B, 11 sync
// - clear select 10 clears on B events
// - pulse-width mode disables capture, drives pin
// - pulse-width mode drops simultaneous A and B match
// - pulse-width output high on A, low B
// - channel 2 phase mode counts up/down
// - flag clears after read one, write zero
// - wrap flag on counted FFFF to 0 or 0 to FFFF, dropped when a clear coincides
module mctarb_timer
  import mctarb_pkg::*;
#(
  parameter int NCH = MCTARB_CHANNELS
)
(
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  // capture inputs, one pair per channel
  input  wire logic [NCH-1:0]  capture_in_a,
  input  wire logic [NCH-1:0]  capture_in_b,
  // phase inputs for channel 2
  input  wire logic            ext_phase_in_a,
  input  wire logic            ext_phase_in_b,
  // compare outputs
  output logic [NCH-1:0]       channel_output_a,
  output logic [NCH-1:0]       channel_output_a_oe
);

  //////////////////////////////////////////////////////////////////////////
  // state

  logic [15:0]          cnt_reg [NCH];
  logic [15:0]          gra_reg [NCH];
  logic [15:0]          grb_reg [NCH];
  logic [7:0]           cctl_reg [NCH];
  logic [7:0]           ioc_reg [NCH];
  logic [NCH-1:0]       start_reg;
  logic [NCH-1:0]       sync_reg;
  logic [7:0]           mode_reg;
  logic [ST_PER_CH*NCH-1:0] status_reg;
  logic [ST_PER_CH*NCH-1:0] armed_reg;
  logic [NCH-1:0]       out_reg;
  logic [NCH-1:0]       cap_a_prev_reg;
  logic [NCH-1:0]       cap_b_prev_reg;
  logic [31:0]          rdata_reg;
  logic                 err_reg;

  logic [PRESCALE_TAPS-1:0] ptick;
  logic                 step_up;
  logic                 step_down;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  // merge the enabled low two byte lanes of a write into a 16-bit value
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    logic [15:0] r;
    r = old;
    if (st[0])
      r[7:0] = wd[7:0];
    if (st[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction : merge16

  function automatic logic [7:0] merge8(input logic [7:0]  old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  st);
    return st[0] ? wd[7:0] : old;
  endfunction : merge8

  //////////////////////////////////////////////////////////////////////////
  // bus decode

  logic       setup_ph;
  logic       access_ph;
  logic [1:0] a_ch;
  logic [4:0] a_off;
  logic       a_is_ch;
  logic       a_known;
  logic       cnt_addr;
  logic       byte_wr;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign a_ch      = paddr[6:5];
  assign a_off     = paddr[4:0];
  assign a_is_ch   = ~paddr[7] && (int'(a_ch) < NCH);
  assign cnt_addr  = a_is_ch && (a_off == OFF_COUNTER) && pwrite;
  assign byte_wr   = pstrb[1:0] != 2'b11;

  always_comb
  begin
    a_known = 1'b0;
    if (a_is_ch)
      a_known = a_off inside {OFF_COUNTER, OFF_GENERAL_A, OFF_GENERAL_B,
                              OFF_CHAN_CTRL, OFF_IO_CTRL};
    else
      a_known = paddr inside {ADDR_START, ADDR_SYNC, ADDR_MODE,
                              ADDR_STATUS, ADDR_PIN_STATE};
  end

  // one-cycle access phase; read data is taken in the setup phase so a
  // capture landing in the access phase cannot change what is read
  assign pready  = 1'b1;
  assign prdata  = rdata_reg;
  assign pslverr = access_ph & err_reg;

  //////////////////////////////////////////////////////////////////////////
  // sources of count pulses

  mctarb_prescale #(
    .TAPS (PRESCALE_TAPS)
  ) u_prescale (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (ptick)
  );

  mctarb_phase u_phase (
    .pclk           (pclk),
    .presetn        (presetn),
    .ext_phase_in_a (ext_phase_in_a),
    .ext_phase_in_b (ext_phase_in_b),
    .step_up        (step_up),
    .step_down      (step_down)
  );

  //////////////////////////////////////////////////////////////////////////
  // per-channel event resolution, all channels in the same cycle

  logic [NCH-1:0] raw_tick;
  logic [NCH-1:0] tick;
  logic [NCH-1:0] dir_down;
  logic [NCH-1:0] pwm;
  logic [NCH-1:0] cm_a;
  logic [NCH-1:0] cm_b;
  logic [NCH-1:0] cap_a;
  logic [NCH-1:0] cap_b;
  logic [NCH-1:0] own_clr;
  logic [NCH-1:0] clr;
  logic [NCH-1:0] cnt_wr;
  logic [NCH-1:0] gra_wr;
  logic [NCH-1:0] grb_wr;
  logic [NCH-1:0] wrap;
  logic [15:0]    cnt_wval;

  always_comb
  begin
    cnt_wval = merge16(cnt_reg[a_ch], pwdata, pstrb);
    for (int c = 0; c < NCH; c++)
    begin
      pwm[c] = mode_reg[MODE_PWM_LSB + c];
      dir_down[c] = 1'b0;
      if (c == 2 && mode_reg[MODE_PHASE])
      begin
        raw_tick[c] = start_reg[c] & (step_up | step_down);
        dir_down[c] = step_down;
      end
      else
        raw_tick[c] = start_reg[c] &
                      ptick[cctl_reg[c][CC_PRESCALE_LSB +: 2]];
      // a write to a synced counter also reaches every other synced counter
      cnt_wr[c] = access_ph && cnt_addr &&
                  (int'(a_ch) == c ||
                   (sync_reg[c] && sync_reg[a_ch]));
      tick[c] = raw_tick[c] & ~cnt_wr[c];
      if (setup_ph && cnt_addr && byte_wr &&
          (int'(a_ch) == c || (sync_reg[c] && sync_reg[a_ch])))
        tick[c] = 1'b0;
      gra_wr[c] = access_ph && pwrite && a_is_ch && int'(a_ch) == c &&
                  a_off == OFF_GENERAL_A;
      grb_wr[c] = access_ph && pwrite && a_is_ch && int'(a_ch) == c &&
                  a_off == OFF_GENERAL_B;
      // match fires as the counter leaves the matching count
      cm_a[c] = tick[c] && cnt_reg[c] == gra_reg[c] && !gra_wr[c];
      cm_b[c] = tick[c] && cnt_reg[c] == grb_reg[c] && !grb_wr[c];
      if (pwm[c] && cm_a[c] && cm_b[c])
      begin
        cm_a[c] = 1'b0;
        cm_b[c] = 1'b0;
      end
      cap_a[c] = !pwm[c] && ioc_reg[c][IO_CAPTURE_A] &&
                 capture_in_a[c] && !cap_a_prev_reg[c];
      cap_b[c] = !pwm[c] && ioc_reg[c][IO_CAPTURE_B] &&
                 capture_in_b[c] && !cap_b_prev_reg[c];
      case (cctl_reg[c][CC_CLEAR_HI:CC_CLEAR_LO])
        CLR_ON_A: own_clr[c] = cm_a[c] | cap_a[c];
        CLR_ON_B: own_clr[c] = cm_b[c] | cap_b[c];
        default:  own_clr[c] = 1'b0;
      endcase
      wrap[c] = raw_tick[c] &&
                (dir_down[c] ? cnt_reg[c] == CNT_ZERO
                             : cnt_reg[c] == CNT_MAX);
    end
    for (int c = 0; c < NCH; c++)
    begin
      clr[c] = own_clr[c];
      if (cctl_reg[c][CC_CLEAR_HI:CC_CLEAR_LO] == CLR_SYNC && sync_reg[c])
        clr[c] = |(own_clr & sync_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // counters and general registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < NCH; c++)
        cnt_reg[c] <= CNT_ZERO;
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (clr[c])
          cnt_reg[c] <= CNT_ZERO;
        else if (cnt_wr[c])
          cnt_reg[c] <= cnt_wval;
        else if (tick[c])
          cnt_reg[c] <= dir_down[c] ? cnt_reg[c] - 16'h0001
                                    : cnt_reg[c] + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        gra_reg[c] <= CNT_MAX;
        grb_reg[c] <= CNT_MAX;
      end
    end
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (cap_a[c])
          gra_reg[c] <= cnt_reg[c];
        else if (gra_wr[c])
          gra_reg[c] <= merge16(gra_reg[c], pwdata, pstrb);
        if (cap_b[c])
          grb_reg[c] <= cnt_reg[c];
        else if (grb_wr[c])
          grb_reg[c] <= merge16(grb_reg[c], pwdata, pstrb);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_a_prev_reg <= '0;
      cap_b_prev_reg <= '0;
    end
    else
    begin
      cap_a_prev_reg <= capture_in_a;
      cap_b_prev_reg <= capture_in_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        cctl_reg[c] <= 8'h00;
        ioc_reg[c]  <= 8'h00;
      end
      start_reg <= '0;
      sync_reg  <= '0;
      mode_reg  <= 8'h00;
    end
    else if (access_ph && pwrite)
    begin
      if (a_is_ch && a_off == OFF_CHAN_CTRL)
        cctl_reg[a_ch] <= merge8(cctl_reg[a_ch], pwdata, pstrb);
      if (a_is_ch && a_off == OFF_IO_CTRL)
        ioc_reg[a_ch] <= merge8(ioc_reg[a_ch], pwdata, pstrb);
      if (paddr == ADDR_START && pstrb[0])
        start_reg <= pwdata[NCH-1:0];
      if (paddr == ADDR_SYNC && pstrb[0])
        sync_reg <= pwdata[NCH-1:0];
      if (paddr == ADDR_MODE)
        mode_reg <= merge8(mode_reg, pwdata, pstrb);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // status flags: armed with the value they hold in a read's access phase, cleared by writing zero

  logic [ST_PER_CH*NCH-1:0] st_set;
  logic [ST_PER_CH*NCH-1:0] st_clr;
  logic                     st_wr;

  assign st_wr = access_ph && pwrite && paddr == ADDR_STATUS &&
                 pstrb[1:0] == 2'b11;

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      st_set[ST_PER_CH*c + ST_MATCH_A] = cm_a[c] | cap_a[c];
      st_set[ST_PER_CH*c + ST_MATCH_B] = cm_b[c] | cap_b[c];
      st_set[ST_PER_CH*c + ST_WRAP]    = wrap[c] & ~clr[c];
    end
    st_clr = st_wr ? (armed_reg & ~pwdata[ST_PER_CH*NCH-1:0]) : '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_reg <= '0;
      armed_reg  <= '0;
    end
    else
    begin
      // a new event in the clearing cycle keeps its flag set
      status_reg <= (status_reg & ~st_clr) | st_set;
      if (access_ph && !pwrite && paddr == ADDR_STATUS)
        armed_reg <= status_reg;
      else if (st_wr)
        armed_reg <= '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // compare outputs

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_reg <= '0;
    else
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (pwm[c])
        begin
          if (cm_a[c])
            out_reg[c] <= 1'b1;
          else if (cm_b[c])
            out_reg[c] <= 1'b0;
        end
        else if (cm_a[c])
        begin
          case (ioc_reg[c][IO_ACT_A_LSB +: 2])
            ACT_LOW:    out_reg[c] <= 1'b0;
            ACT_HIGH:   out_reg[c] <= 1'b1;
            ACT_TOGGLE: out_reg[c] <= ~out_reg[c];
            default:    out_reg[c] <= out_reg[c];
          endcase
        end
      end
    end
  end

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
      channel_output_a_oe[c] = pwm[c] ||
        (!ioc_reg[c][IO_CAPTURE_A] &&
         ioc_reg[c][IO_ACT_A_LSB +: 2] != ACT_NONE);
  end

  assign channel_output_a = out_reg;

  //////////////////////////////////////////////////////////////////////////
  // read data, sampled in the setup phase

  logic [31:0] rmux;

  always_comb
  begin
    rmux = 32'h0000_0000;
    if (a_is_ch)
    begin
      case (a_off)
        OFF_COUNTER:   rmux[15:0] = cnt_reg[a_ch];
        OFF_GENERAL_A: rmux[15:0] = gra_reg[a_ch];
        OFF_GENERAL_B: rmux[15:0] = grb_reg[a_ch];
        OFF_CHAN_CTRL: rmux[7:0]  = cctl_reg[a_ch];
        OFF_IO_CTRL:   rmux[7:0]  = ioc_reg[a_ch];
        default:       rmux = 32'h0000_0000;
      endcase
    end
    else
    begin
      case (paddr)
        ADDR_START:     rmux[NCH-1:0] = start_reg;
        ADDR_SYNC:      rmux[NCH-1:0] = sync_reg;
        ADDR_MODE:      rmux[7:0] = mode_reg;
        ADDR_STATUS:    rmux[ST_PER_CH*NCH-1:0] = status_reg;
        ADDR_PIN_STATE: rmux[NCH-1:0] = out_reg;
        default:        rmux = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end
    else if (setup_ph)
    begin
      rdata_reg <= pwrite ? 32'h0000_0000 : rmux;
      err_reg   <= ~a_known;
    end
  end

endmodule : mctarb_timer

/* File: mctarb_timer_chk.sv */
// concurrent checks on the timer's apb and compare pin ports
module mctarb_timer_chk
  import mctarb_pkg::*;
#(
  parameter int NCH = MCTARB_CHANNELS
)
(
  // clock and reset
  input wire logic            pclk,
  input wire logic            presetn,
  // apb slave
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [3:0]      pstrb,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // capture and phase pins
  input wire logic [NCH-1:0]  capture_in_a,
  input wire logic [NCH-1:0]  capture_in_b,
  input wire logic            ext_phase_in_a,
  input wire logic            ext_phase_in_b,
  // compare outputs
  input wire logic [NCH-1:0]  channel_output_a,
  input wire logic [NCH-1:0]  channel_output_a_oe
);
  logic [NCH-1:0] mode_sh;
  logic           acc;
  logic           mapped;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign acc = psel && penable;
  // five words per channel window, then shared words up to pin state
  assign mapped = paddr[1:0] == 2'h0 && paddr <= ADDR_PIN_STATE &&
                  (paddr >= ADDR_START || paddr[4:0] <= OFF_IO_CTRL);
  // shadow of the pulse-width bits as software last wrote them
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mode_sh <= '0;
    else if (acc && pwrite && paddr == ADDR_MODE && pstrb[0])
      mode_sh <= pwdata[NCH-1:0];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read(logic [7:0] a);
    s_setup ##0 (!pwrite && paddr == a);
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready dropped");
  a_err_access: assert property (pslverr |-> acc)
    else $error("error flag outside access");
  a_err_decode: assert property (acc |-> pslverr == !mapped)
    else $error("error flag disagrees with decode");
  a_hole_zero: assert property (s_setup ##0 !mapped |=> prdata == 32'h0)
    else $error("unmapped access returned data");
  a_write_zero: assert property (s_setup ##0 pwrite |=> prdata == 32'h0)
    else $error("write returned data");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  a_mode_read: assert property (s_read(ADDR_MODE) |=>
    prdata[NCH-1:0] == mode_sh) else $error("mode readback wrong");
  a_pin_read: assert property (s_read(ADDR_PIN_STATE) |=>
    prdata[NCH-1:0] == $past(channel_output_a)) else $error("pin readback");
  a_pwm_oe: assert property ((mode_sh & ~channel_output_a_oe) == '0)
    else $error("pulse-width channel not driving its pin");
  a_reset_quiet: assert property ($rose(presetn) |->
    channel_output_a_oe == '0 && channel_output_a == '0 && !pslverr)
    else $error("outputs active after reset");
endmodule : mctarb_timer_chk

bind mctarb_timer mctarb_timer_chk #(.NCH(NCH)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .capture_in_a(capture_in_a), .capture_in_b(capture_in_b),
  .ext_phase_in_a(ext_phase_in_a), .ext_phase_in_b(ext_phase_in_b),
  .channel_output_a(channel_output_a),
  .channel_output_a_oe(channel_output_a_oe)
);

/* File: testbench.sv */
// self-checking bench for the three-channel timer arbitration block
module testbench
  import mctarb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, e, v;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  logic [2:0]  cap_a = 3'h0;
  logic [2:0]  outa, oe;
  logic        ph_a = 1'b0;
  logic        ph_b = 1'b0;
  logic [1:0]  pat [8] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0};
  int          bad_count = 0;
  int          comparisons = 0;
  int          n;
  mctarb_timer #(.NCH(3)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_in_a(cap_a), .capture_in_b(cap_a),
    .ext_phase_in_a(ph_a), .ext_phase_in_b(ph_b),
    .channel_output_a(outa), .channel_output_a_oe(oe)
  );
  mctarb_apb_bfm bfm_u (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );
  initial
    forever #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    bfm_u.xfer(w, a, d, s, r, e);
    if (bfm_u.tmo)
    begin
      bad_count++;
      results();
    end
  endtask : go
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    go(1'b1, a, d, s);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    go(1'b0, a, 32'h0, 4'h0);
  endtask : rd
  function automatic logic [7:0] ra(input int c, input logic [4:0] o);
    return 8'(c * CH_STRIDE) + 8'(o);
  endfunction : ra
  // counts falling edges until the channel pin changes; settled sampling
  task automatic wchg(input int c);
    logic w0;
    w0 = outa[c];
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (outa[c] === w0 && n < 200);
    if (n >= 200)
    begin
      bad_count++;
      results();
    end
  endtask : wchg
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(ra(0, OFF_COUNTER));
    chk(r, 32'h0);
    rd(ra(0, OFF_GENERAL_A));
    chk(r, 32'h0000FFFF);
    rd(8'h7C);
    chk({r[30:0], e}, 32'h1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_period();
    wr(ra(0, OFF_GENERAL_A), 32'h3);
    wr(ra(0, OFF_CHAN_CTRL), 32'h20);
    wr(ra(0, OFF_IO_CTRL), 32'h3);
    wr(ra(1, OFF_GENERAL_A), 32'h2);
    wr(ra(1, OFF_GENERAL_B), 32'h5);
    wr(ra(1, OFF_CHAN_CTRL), 32'h40);
    wr(ra(1, OFF_IO_CTRL), 32'h3);
    wr(ADDR_START, 32'h3);
    for (int c = 0; c < 2; c++)
    begin
      wchg(c);
      wchg(c);
      chk(32'(n), c ? 32'h6 : 32'h4);
    end
    $display("t_period done");
  endtask : t_period
  task automatic t_pwm();
    wr(ra(1, OFF_GENERAL_B), 32'h6);
    wr(ra(1, OFF_IO_CTRL), 32'h4);
    wr(ADDR_MODE, 32'h2);
    rd(ADDR_MODE);
    wchg(1);
    if (outa[1] !== 1'b1)
      wchg(1);
    wchg(1);
    chk(32'(n), 32'h4);
    wchg(1);
    chk(32'(n), 32'h3);
    @(posedge pclk);
    cap_a[1] <= 1'b1;
    rd(ADDR_PIN_STATE);
    cap_a[1] <= 1'b0;
    rd(ra(1, OFF_GENERAL_A));
    chk(r, 32'h2);
    wr(ra(1, OFF_GENERAL_A), 32'h6);
    @(negedge pclk);
    v = outa[1];
    repeat (16)
    begin
      @(negedge pclk);
      chk(32'(outa[1]), 32'(v));
    end
    $display("t_pwm done");
  endtask : t_pwm
  task automatic t_flags();
    wr(ADDR_START, 32'h0);
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STATUS);
    chk(r & 32'h1, 32'h1);
    wr(ADDR_STATUS, 32'h0);
    rd(ADDR_STATUS);
    chk(r & 32'h1, 32'h0);
    $display("t_flags done");
  endtask : t_flags
  task automatic t_sync();
    wr(ADDR_SYNC, 32'h3);
    wr(ra(0, OFF_COUNTER), 32'h1200);
    wr(ra(0, OFF_COUNTER), 32'hAB, 4'h1);
    for (int c = 0; c < 3; c++)
    begin
      rd(ra(c, OFF_COUNTER));
      chk(r, (c == 2) ? 32'h0 : 32'h12AB);
    end
    wr(ADDR_SYNC, 32'h0);
    $display("t_sync done");
  endtask : t_sync
  task automatic t_ch2();
    wr(ra(2, OFF_IO_CTRL), 32'h44);
    wr(ra(2, OFF_COUNTER), 32'h1234);
    cap_a[2] <= 1'b1;
    rd(ra(2, OFF_GENERAL_A));
    cap_a[2] <= 1'b0;
    rd(ra(2, OFF_GENERAL_A));
    chk(r, 32'h1234);
    rd(ra(2, OFF_GENERAL_B));
    chk(r, 32'h1234);
    wr(ra(2, OFF_COUNTER), 32'hFFFF);
    wr(ADDR_START, 32'h4);
    wr(ADDR_START, 32'h0);
    rd(ADDR_STATUS);
    chk(r & 32'h100, 32'h100);
    wr(ra(2, OFF_COUNTER), 32'h10);
    wr(ADDR_MODE, 32'h40);
    wr(ADDR_START, 32'h4);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge pclk);
      {ph_a, ph_b} <= pat[i];
      repeat (4) @(posedge pclk);
      if (i % 4 == 3)
      begin
        rd(ra(2, OFF_COUNTER));
        chk(r, (i < 4) ? 32'h14 : 32'h10);
      end
    end
    $display("t_ch2 done");
  endtask : t_ch2
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_period();
    t_pwm();
    t_flags();
    t_sync();
    t_ch2();
    results();
  end
endmodule : testbench
